// ==== llps_pkg.sv ====
// Functional notes
// - Nonzero lag count hands both relays to staging.
// - At most two auxiliary pumps, one relay each.
// - Staging suppresses all other relay functions.
// - Lag pumps come on relay one first.
// - Stage needs pressure at or below setpoint minus offset.
// - Stage waits for the stage delay to elapse.
// - Stage first closes the next relay.
// - Then command maximum speed minus speed cut.
// - Hold reduced speed for hold time, then regulate.
// - Release needs pressure at or above setpoint plus offset.
// - Release waits for the release delay to elapse.
// - Release needs speed within minimum plus window.
// - Release first opens the removed pump's relay.
// - Then command minimum speed plus release boost.
// - Hold boosted speed for hold time, then regulate.
// - Multiplex needs lag count and rotation time nonzero.
// - Multiplex master closes relay when pressure is short.
// - First unit in, last out, is primary.
// - Primary role rotates each rotation cycle time.
// - A non-primary master is always second in.
`default_nettype none

package llps_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses, one 32-bit word each).
  // ---------------------------------------------------------------------------
  localparam logic [7:0] LLPS_OFS_CTRL   = 8'h00; // Lag count and rotation time.
  localparam logic [7:0] LLPS_OFS_SETPT  = 8'h04; // Pressure setpoint.
  localparam logic [7:0] LLPS_OFS_POFS   = 8'h08; // Call and release pressure offsets.
  localparam logic [7:0] LLPS_OFS_DELAY  = 8'h0C; // Call and release delays in ticks.
  localparam logic [7:0] LLPS_OFS_HOLD   = 8'h10; // Call and release hold times in ticks.
  localparam logic [7:0] LLPS_OFS_FLIM   = 8'h14; // Minimum and maximum frequency.
  localparam logic [7:0] LLPS_OFS_SADJ   = 8'h18; // Speed cut and release boost.
  localparam logic [7:0] LLPS_OFS_WIN    = 8'h1C; // Release speed window.
  localparam logic [7:0] LLPS_OFS_STATUS = 8'h20; // Read-only status.

  // ---------------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------------
  localparam int LLPS_LO_LSB     = 0;  // Low half-word of a paired register.
  localparam int LLPS_HI_LSB     = 16; // High half-word of a paired register.
  localparam int LLPS_LAG_LSB    = 0;  // Lag pump count, two bits.
  localparam int LLPS_ST_RELAY   = 0;  // Status: relay bits 1:0.
  localparam int LLPS_ST_STAGE   = 2;  // Status: staging active.
  localparam int LLPS_ST_MUX     = 3;  // Status: multiplex active.
  localparam int LLPS_ST_PRIM    = 4;  // Status: primary unit, bits 5:4.
  localparam int LLPS_ST_COUNT   = 6;  // Status: running units, bits 7:6.
  localparam int LLPS_ST_PHASE   = 8;  // Status: phase, bits 9:8.
  localparam int LLPS_ST_OVR     = 10; // Status: speed override active.

  // ---------------------------------------------------------------------------
  // Reset values.
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  LLPS_RST_LAG   = 2'h0;
  localparam logic [15:0] LLPS_RST_ZERO  = 16'h0000;
  localparam logic [15:0] LLPS_RST_FMAX  = 16'h0258; // 60.0 Hz in 0.1 Hz units.
  localparam logic [15:0] LLPS_RST_FMIN  = 16'h012C; // 30.0 Hz in 0.1 Hz units.
  localparam logic [1:0]  LLPS_MAX_LAG   = 2'h2;
  localparam logic [1:0]  LLPS_ONE_UNIT  = 2'h1;

  // ---------------------------------------------------------------------------
  // Timing.
  // ---------------------------------------------------------------------------
  localparam int LLPS_CLK_PERIOD_NS = 20;        // 50 MHz control clock.
  localparam int LLPS_TICK_NS       = 1_000_000; // One timer tick is 1 ms.
  localparam int LLPS_TICK_CYCLES   = LLPS_TICK_NS / LLPS_CLK_PERIOD_NS;
  localparam int LLPS_SEC_TICKS     = 1000;      // Ticks in one second.

  // Sequencing phases.
  typedef enum logic [1:0] {
    LLPS_REGULATE,
    LLPS_CALL_HOLD,
    LLPS_RELEASE_HOLD
  } llps_phase_t;

endpackage : llps_pkg

`default_nettype wire

// ==== llps_stager.sv ====
`default_nettype none

module llps_stager
  import llps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = LLPS_TICK_CYCLES, // Clock cycles per 1 ms tick.
  parameter int unsigned SEC_TICKS   = LLPS_SEC_TICKS    // Ticks per rotation second.
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Process measurements from the drive.
  input  wire logic [15:0] pressure,
  input  wire logic [15:0] drive_freq,
  // Ordinary relay functions from the interface logic.
  input  wire logic [1:0]  relay_other_func,
  // Relay contacts and master control.
  output logic             relay_one_contact,
  output logic             relay_two_contact,
  output logic             master_run,
  // Speed override toward the pressure regulator.
  output logic             speed_override,
  output logic      [15:0] speed_override_value,
  // Mode indications.
  output logic             staging_active,
  output logic             multiplex_active,
  output logic      [1:0]  primary_unit
);

  // ---------------------------------------------------------------------------
  // Settings registers.
  // ---------------------------------------------------------------------------
  logic [1:0]  lag_setting;          // Raw lag pump count.
  logic [15:0] rotation_time;        // Rotation cycle time in seconds.
  logic [15:0] setpoint;             // Pressure setpoint.
  logic [15:0] call_pressure_offset; // Offset below setpoint for a call.
  logic [15:0] release_pressure_offset; // Offset above setpoint for a release.
  logic [15:0] call_delay;           // Call delay in ticks.
  logic [15:0] release_delay;        // Release delay in ticks.
  logic [15:0] call_hold_duration;   // Reduced-speed hold in ticks.
  logic [15:0] release_hold_duration; // Boosted-speed hold in ticks.
  logic [15:0] min_freq;             // Minimum drive frequency.
  logic [15:0] max_freq;             // Maximum drive frequency.
  logic [15:0] call_speed_cut;       // Speed reduction after a call.
  logic [15:0] release_speed_boost;  // Speed boost after a release.
  logic [15:0] release_speed_window; // Window above minimum for a release.

  // ---------------------------------------------------------------------------
  // Internal state.
  // ---------------------------------------------------------------------------
  llps_phase_t phase;                // Sequencing phase.
  llps_phase_t phase_q;              // Phase one cycle late, so the relay moves first.
  logic [31:0] tick_cnt;             // Tick prescaler.
  logic        tick;                 // One-cycle pulse every tick.
  logic [15:0] call_timer;           // Call delay timer.
  logic [15:0] release_timer;        // Release delay timer.
  logic [15:0] hold_timer;           // Hold timer for both hold phases.
  logic [15:0] sec_cnt;              // Ticks within the current second.
  logic [15:0] rot_cnt;              // Seconds since the last rotation.
  logic [1:0]  run_count;            // Units running, including the primary.
  logic [1:0]  primary;              // Current primary unit, zero is the master.
  logic [1:0]  relay_q;              // Relay contact flip-flops.

  // Combinational terms.
  logic [1:0]  lag_count;            // Lag count clamped to two.
  logic [1:0]  max_count;            // Largest number of running units.
  logic        stage_on;             // Lead/lag staging in force.
  logic        mux_on;               // Multiplex in force.
  logic        call_cond;            // Pressure has fallen far enough.
  logic        release_cond;         // Pressure has risen far enough.
  logic        window_cond;          // Speed sits in the release window.
  logic        call_now;             // All call conditions met.
  logic        release_now;          // All release conditions met.
  logic [16:0] call_level;           // Pressure plus call offset.
  logic [16:0] release_level;        // Setpoint plus release offset.
  logic [16:0] window_top;           // Minimum plus window.
  logic [16:0] boost_sum;            // Minimum plus boost.
  logic [15:0] cut_speed;            // Saturated reduced speed.
  logic [15:0] boost_speed;          // Saturated boosted speed.

  // Position of a unit in the staging order for a given primary.
  function automatic logic [1:0] llps_pos(input logic [1:0] unit, input logic [1:0] prim);
    logic [1:0] result;
    result = unit;
    if (prim != 2'h0) begin
      if (unit == prim) begin
        result = 2'h0;
      end else if (unit == 2'h0) begin
        result = 2'h1;
      end else begin
        result = 2'h2;
      end
    end
    return result;
  endfunction : llps_pos

  // ---------------------------------------------------------------------------
  // Mode decode and conditions.
  // ---------------------------------------------------------------------------

  // Clamp the lag count and decide which modes are in force.
  always_comb begin
    lag_count = (lag_setting > LLPS_MAX_LAG) ? LLPS_MAX_LAG : lag_setting;
    max_count = lag_count + LLPS_ONE_UNIT;
    stage_on  = (lag_count != 2'h0);
    mux_on    = stage_on && (rotation_time != LLPS_RST_ZERO);
  end

  // Compare pressure and speed against their thresholds in 17 bits.
  always_comb begin
    call_level    = {1'b0, pressure} + {1'b0, call_pressure_offset};
    release_level = {1'b0, setpoint} + {1'b0, release_pressure_offset};
    window_top    = {1'b0, min_freq} + {1'b0, release_speed_window};
    boost_sum     = {1'b0, min_freq} + {1'b0, release_speed_boost};
    call_cond     = (call_level <= {1'b0, setpoint});
    release_cond  = ({1'b0, pressure} >= release_level);
    window_cond   = (drive_freq >= min_freq) &&
                    ({1'b0, drive_freq} <= window_top);
    cut_speed     = (call_speed_cut < max_freq) ? (max_freq - call_speed_cut) : LLPS_RST_ZERO;
    boost_speed   = boost_sum[16] ? 16'hFFFF : boost_sum[15:0];
  end

  // Decide whether a call or a release fires this cycle.
  always_comb begin
    call_now    = stage_on && call_cond && (call_timer >= call_delay) &&
                  (run_count < max_count);
    release_now = stage_on && release_cond && window_cond &&
                  (release_timer >= release_delay) &&
                  (run_count > LLPS_ONE_UNIT);
  end

  // ---------------------------------------------------------------------------
  // Tick and rotation timing.
  // ---------------------------------------------------------------------------

  // Divide the clock down to a 1 ms tick.
  always_ff @(posedge clock) begin
    if (rst) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (tick_cnt >= (TICK_CYCLES - 32'd1)) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'd1;
      tick     <= 1'b0;
    end
  end

  // Count seconds and advance the primary role when the cycle time runs out.
  always_ff @(posedge clock) begin
    if (rst) begin
      sec_cnt <= LLPS_RST_ZERO;
      rot_cnt <= LLPS_RST_ZERO;
      primary <= 2'h0;
    end else if (!mux_on) begin
      // Outside multiplex the master stays primary.
      sec_cnt <= LLPS_RST_ZERO;
      rot_cnt <= LLPS_RST_ZERO;
      primary <= 2'h0;
    end else if (tick) begin
      if ({16'h0000, sec_cnt} >= (SEC_TICKS - 32'd1)) begin
        sec_cnt <= LLPS_RST_ZERO;
        if (rot_cnt >= (rotation_time - 16'h0001)) begin
          rot_cnt <= LLPS_RST_ZERO;
          primary <= (primary >= lag_count) ? 2'h0 : (primary + 2'h1);
        end else begin
          rot_cnt <= rot_cnt + 16'h0001;
        end
      end else begin
        sec_cnt <= sec_cnt + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Delay timers.
  // ---------------------------------------------------------------------------

  // Call delay timer runs only while pressure stays low in the regulate phase.
  always_ff @(posedge clock) begin
    if (rst) begin
      call_timer <= LLPS_RST_ZERO;
    end else if (!call_cond || (phase != LLPS_REGULATE) || call_now) begin
      call_timer <= LLPS_RST_ZERO;
    end else if (tick && (call_timer != 16'hFFFF)) begin
      call_timer <= call_timer + 16'h0001;
    end
  end

  // Release delay timer runs only while pressure stays high in the regulate phase.
  always_ff @(posedge clock) begin
    if (rst) begin
      release_timer <= LLPS_RST_ZERO;
    end else if (!release_cond || (phase != LLPS_REGULATE) || release_now) begin
      release_timer <= LLPS_RST_ZERO;
    end else if (tick && (release_timer != 16'hFFFF)) begin
      release_timer <= release_timer + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer.
  // ---------------------------------------------------------------------------
  // Step the running count and the hold phases.
  always_ff @(posedge clock) begin
    if (rst) begin
      phase      <= LLPS_REGULATE;
      run_count  <= LLPS_ONE_UNIT;
      hold_timer <= LLPS_RST_ZERO;
    end else begin
      case (phase)
        LLPS_REGULATE: begin
          hold_timer <= LLPS_RST_ZERO;
          if (run_count > max_count) begin
            // A smaller lag count drops the surplus units at once.
            run_count <= max_count;
          end else if (call_now) begin
            run_count <= run_count + LLPS_ONE_UNIT;
            phase     <= LLPS_CALL_HOLD;
          end else if (release_now) begin
            run_count <= run_count - LLPS_ONE_UNIT;
            phase     <= LLPS_RELEASE_HOLD;
          end
        end
        LLPS_CALL_HOLD: begin
          if (hold_timer >= call_hold_duration) begin
            phase <= LLPS_REGULATE;
          end else if (tick) begin
            hold_timer <= hold_timer + 16'h0001;
          end
        end
        LLPS_RELEASE_HOLD: begin
          if (hold_timer >= release_hold_duration) begin
            phase <= LLPS_REGULATE;
          end else if (tick) begin
            hold_timer <= hold_timer + 16'h0001;
          end
        end
        default: begin
          phase <= LLPS_REGULATE;
        end
      endcase
    end
  end

  // Command the override speed one cycle after the relay has moved.
  always_ff @(posedge clock) begin
    if (rst) begin
      speed_override       <= 1'b0;
      speed_override_value <= LLPS_RST_ZERO;
    end else if (phase_q == LLPS_CALL_HOLD) begin
      speed_override       <= 1'b1;
      speed_override_value <= cut_speed;
    end else if (phase_q == LLPS_RELEASE_HOLD) begin
      speed_override       <= 1'b1;
      speed_override_value <= boost_speed;
    end else begin
      speed_override       <= 1'b0;
      speed_override_value <= LLPS_RST_ZERO;
    end
  end

  // ---------------------------------------------------------------------------
  // Relay outputs.
  // ---------------------------------------------------------------------------
  // Each relay follows its unit's place in the order, or its ordinary function.
  for (genvar i = 0; i < 2; i++) begin : g_relay
    always_ff @(posedge clock) begin
      if (rst) begin
        relay_q[i] <= 1'b0;
      end else if (stage_on) begin
        relay_q[i] <= (2'(i + 1) <= lag_count) &&
                      (llps_pos(2'(i + 1), primary) < run_count);
      end else begin
        relay_q[i] <= relay_other_func[i];
      end
    end
  end

  assign relay_one_contact = relay_q[0];
  assign relay_two_contact = relay_q[1];

  // Master run, mode flags, primary index and the delayed phase.
  always_ff @(posedge clock) begin
    if (rst) begin
      phase_q          <= LLPS_REGULATE;
      master_run       <= 1'b1;
      staging_active   <= 1'b0;
      multiplex_active <= 1'b0;
      primary_unit     <= 2'h0;
    end else begin
      phase_q          <= phase;
      master_run       <= !mux_on || (llps_pos(2'h0, primary) < run_count);
      staging_active   <= stage_on;
      multiplex_active <= mux_on;
      primary_unit     <= primary;
    end
  end

  // ---------------------------------------------------------------------------
  // Register port.
  // ---------------------------------------------------------------------------
  // Write decode for the settings registers.
  always_ff @(posedge clock) begin
    if (rst) begin
      lag_setting             <= LLPS_RST_LAG;
      rotation_time           <= LLPS_RST_ZERO;
      setpoint                <= LLPS_RST_ZERO;
      call_pressure_offset    <= LLPS_RST_ZERO;
      release_pressure_offset <= LLPS_RST_ZERO;
      call_delay              <= LLPS_RST_ZERO;
      release_delay           <= LLPS_RST_ZERO;
      call_hold_duration      <= LLPS_RST_ZERO;
      release_hold_duration   <= LLPS_RST_ZERO;
      min_freq                <= LLPS_RST_FMIN;
      max_freq                <= LLPS_RST_FMAX;
      call_speed_cut          <= LLPS_RST_ZERO;
      release_speed_boost     <= LLPS_RST_ZERO;
      release_speed_window    <= LLPS_RST_ZERO;
    end else if (reg_wr) begin
      case (reg_addr)
        LLPS_OFS_CTRL: begin
          lag_setting   <= reg_wdata[LLPS_LAG_LSB +: 2];
          rotation_time <= reg_wdata[LLPS_HI_LSB +: 16];
        end
        LLPS_OFS_SETPT: begin
          setpoint <= reg_wdata[LLPS_LO_LSB +: 16];
        end
        LLPS_OFS_POFS: begin
          call_pressure_offset    <= reg_wdata[LLPS_LO_LSB +: 16];
          release_pressure_offset <= reg_wdata[LLPS_HI_LSB +: 16];
        end
        LLPS_OFS_DELAY: begin
          call_delay    <= reg_wdata[LLPS_LO_LSB +: 16];
          release_delay <= reg_wdata[LLPS_HI_LSB +: 16];
        end
        LLPS_OFS_HOLD: begin
          call_hold_duration    <= reg_wdata[LLPS_LO_LSB +: 16];
          release_hold_duration <= reg_wdata[LLPS_HI_LSB +: 16];
        end
        LLPS_OFS_FLIM: begin
          min_freq <= reg_wdata[LLPS_LO_LSB +: 16];
          max_freq <= reg_wdata[LLPS_HI_LSB +: 16];
        end
        LLPS_OFS_SADJ: begin
          call_speed_cut      <= reg_wdata[LLPS_LO_LSB +: 16];
          release_speed_boost <= reg_wdata[LLPS_HI_LSB +: 16];
        end
        LLPS_OFS_WIN: begin
          release_speed_window <= reg_wdata[LLPS_LO_LSB +: 16];
        end
        default: begin
          // Writes elsewhere, status included, are ignored.
        end
      endcase
    end
  end

  // Read data stands for exactly one cycle after the read strobe.
  always_ff @(posedge clock) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      case (reg_addr)
        LLPS_OFS_CTRL:   reg_rdata <= {rotation_time, 14'h0000, lag_setting};
        LLPS_OFS_SETPT:  reg_rdata <= {16'h0000, setpoint};
        LLPS_OFS_POFS:   reg_rdata <= {release_pressure_offset, call_pressure_offset};
        LLPS_OFS_DELAY:  reg_rdata <= {release_delay, call_delay};
        LLPS_OFS_HOLD:   reg_rdata <= {release_hold_duration, call_hold_duration};
        LLPS_OFS_FLIM:   reg_rdata <= {max_freq, min_freq};
        LLPS_OFS_SADJ:   reg_rdata <= {release_speed_boost, call_speed_cut};
        LLPS_OFS_WIN:    reg_rdata <= {16'h0000, release_speed_window};
        LLPS_OFS_STATUS: begin
          reg_rdata                      <= 32'h0000_0000;
          reg_rdata[LLPS_ST_RELAY +: 2]  <= relay_q;
          reg_rdata[LLPS_ST_STAGE]       <= stage_on;
          reg_rdata[LLPS_ST_MUX]         <= mux_on;
          reg_rdata[LLPS_ST_PRIM +: 2]   <= primary;
          reg_rdata[LLPS_ST_COUNT +: 2]  <= run_count;
          reg_rdata[LLPS_ST_PHASE +: 2]  <= phase;
          reg_rdata[LLPS_ST_OVR]         <= speed_override;
          reg_rdata[LLPS_HI_LSB +: 16]   <= speed_override_value;
        end
        default:         reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : llps_stager

`default_nettype wire

// ==== llps_pump_model.sv ====
`default_nettype none
// Aux starters: each pump follows its own contact after LAT cycles.
module llps_pump_model #(
  parameter int LAT = 1  // Starter pick-up delay in clock cycles.
) (
  input  wire logic       clock, rst, relay_one_contact, relay_two_contact,
  output var  logic [1:0] aux_run
);
  logic [1:0] pipe [LAT];  // Pick-up delay line, one bit per pump.
  always_ff @(posedge clock) begin
    pipe[0] <= rst ? 2'b00 : {relay_two_contact, relay_one_contact};
    for (int i = 1; i < LAT; i++) begin
      pipe[i] <= pipe[i-1];
    end
  end
  assign aux_run = pipe[LAT-1];
endmodule : llps_pump_model
`default_nettype wire

// ==== llps_stager_sva.sv ====
`default_nettype none
module llps_stager_sva (
  input wire logic        clock, rst, reg_rd, master_run, speed_override,
  input wire logic        relay_one_contact, relay_two_contact,
  input wire logic        staging_active, multiplex_active,
  input wire logic [1:0]  relay_other_func, primary_unit,
  input wire logic [15:0] speed_override_value,
  input wire logic [31:0] reg_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic [1:0] rl = {relay_two_contact, relay_one_contact};  // Both contacts.
  wire logic       ll = staging_active && !multiplex_active;     // Plain staging.
  property p_order; ll |-> !relay_two_contact || relay_one_contact; endproperty
  a_order: assert property (p_order) else $error("relay two before one");
  property p_pass; !staging_active ##1 !staging_active |-> rl == $past(relay_other_func);
  endproperty
  a_pass: assert property (p_pass) else $error("relays miss other func");
  property p_one; ll && $past(ll) && $changed(rl) |-> $countones(rl ^ $past(rl)) == 1;
  endproperty
  a_one: assert property (p_one) else $error("two relays moved");
  property p_call; ll && $past(ll) && $changed(rl) |=> speed_override; endproperty
  a_call: assert property (p_call) else $error("no override after step");
  property p_hold; speed_override |-> $stable(rl); endproperty
  a_hold: assert property (p_hold) else $error("relay moved in hold");
  property p_zero; !speed_override |-> speed_override_value == 16'h0000; endproperty
  a_zero: assert property (p_zero) else $error("value without override");
  property p_mux; multiplex_active |-> staging_active; endproperty
  a_mux: assert property (p_mux) else $error("mux without staging");
  property p_run; !multiplex_active |-> master_run; endproperty
  a_run: assert property (p_run) else $error("master asleep");
  property p_prim; primary_unit <= 2'h2; endproperty
  a_prim: assert property (p_prim) else $error("primary out of range");
  property p_rd; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
  c_one: cover property ($rose(relay_one_contact));
  c_two: cover property ($fell(relay_two_contact));
  c_ovr: cover property ($rose(speed_override));
endmodule : llps_stager_sva
bind llps_stager llps_stager_sva chk_u (.*);
`default_nettype wire

// ==== lead_lag_pump_stager_test.sv ====
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module lead_lag_pump_stager_test import llps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [15:0] pressure = 16'h0064, drive_freq = 16'h0200, speed_override_value;
  logic [1:0]  relay_other_func = 0, primary_unit, aux_run;
  logic        relay_one_contact, relay_two_contact, master_run, speed_override;
  logic        staging_active, multiplex_active;
  int          n_fail = 0, n_tests = 0, cyc = 0;
  llps_stager #(.TICK_CYCLES(4), .SEC_TICKS(3)) dut_u (.*);
  llps_pump_model #(.LAT(3)) pump_u (.*);
  initial forever #10 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end
  task print_verdict;
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clock) reg_wr <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clock) reg_rd <= 0;
    @(posedge clock) `CHK("rdata", e, reg_rdata)
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt
  task automatic test_pass;
    rd(LLPS_OFS_FLIM, 32'h0258012C);
    rd(8'h40, 32'h0);
    relay_other_func <= 2'b10;
    wt(3);
    `CHK("other", 2'b10, {relay_two_contact, relay_one_contact})
  endtask : test_pass
  task automatic test_call;
    wr(LLPS_OFS_SETPT, 32'h64);
    wr(LLPS_OFS_POFS, 32'h0005000A);
    wr(LLPS_OFS_DELAY, 32'h00020002);
    wr(LLPS_OFS_HOLD, 32'h00030003);
    wr(LLPS_OFS_SADJ, 32'h0032003C);
    wr(LLPS_OFS_WIN, 32'h28);
    wr(LLPS_OFS_CTRL, 32'h2);
    wt(3);
    `CHK("taken", 2'b00, {relay_two_contact, relay_one_contact})
    `CHK("mux", 1'b0, multiplex_active)
    `CHK("stage", 1'b1, staging_active)
    pressure <= 16'h5A;
    wt(4);
    pressure <= 16'h5B;
    wt(1);
    pressure <= 16'h5A;
    wt(4);
    `CHK("dip", 1'b0, relay_one_contact)
    for (int i = 0; i < 20 && !relay_one_contact; i++) wt(1);
    `CHK("r1 on", 1'b1, relay_one_contact)
    `CHK("r2 off", 1'b0, relay_two_contact)
    wt(1);
    `CHK("cut", 16'h021C, speed_override_value)
    wt(6);
    `CHK("held", 1'b1, speed_override)
    for (int i = 0; i < 20 && speed_override; i++) wt(1);
    wt(2);
    `CHK("delay", 1'b0, relay_two_contact)
    for (int i = 0; i < 30 && !relay_two_contact; i++) wt(1);
    wt(20);
    `CHK("pumps", 2'b11, aux_run)
  endtask : test_call
  task automatic test_release;
    {pressure, drive_freq} <= {16'h0069, 16'h0155};
    wt(16);
    `CHK("window", 1'b1, relay_two_contact)
    drive_freq <= 16'h0154;
    for (int i = 0; i < 20 && relay_two_contact; i++) wt(1);
    `CHK("newest", 2'b01, {relay_two_contact, relay_one_contact})
    wt(1);
    `CHK("boost", 16'h015E, speed_override_value)
    for (int i = 0; i < 20 && speed_override; i++) wt(1);
    pressure <= 16'h0068;
    wt(16);
    `CHK("psi", 1'b1, relay_one_contact)
    pressure <= 16'h0069;
    wt(20);
    `CHK("r1 off", 1'b0, relay_one_contact)
  endtask : test_release
  task automatic test_mux;
    wr(LLPS_OFS_CTRL, 32'h00030002);
    wt(3);
    `CHK("mux on", 1'b1, multiplex_active)
    for (int i = 0; i < 60 && primary_unit != 2'h1; i++) wt(1);
    `CHK("primary", 2'h1, primary_unit)
    `CHK("prim relay", 2'b01, {relay_two_contact, relay_one_contact})
    `CHK("asleep", 1'b0, master_run)
    pressure <= 16'h005A;
    wt(12);
    `CHK("second", 1'b1, master_run)
    `CHK("no third", 2'b01, {relay_two_contact, relay_one_contact})
  endtask : test_mux
  initial begin
    wt(12);
    rst <= 0;
    test_pass();
    test_call();
    test_release();
    test_mux();
    print_verdict();
  end
endmodule : lead_lag_pump_stager_test
`default_nettype wire
